// >>> hw/arc_pkg.sv
// shared constants, types and decode helpers for the result correction block
`default_nettype none
package arc_pkg;

  // register byte offsets
  localparam logic [7:0] FCW_OFS  = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] OFSC_OFS = 8'h08;
  localparam logic [7:0] GAIN_OFS = 8'h0c;
  localparam logic [7:0] RES_OFS  = 8'h10;

  // filter configuration word layout
  localparam int FCW_DEC_LSB  = 0;
  localparam int FCW_DEC_W    = 7;
  localparam int FCW_SMOD_BIT = 7;
  localparam int FCW_AVG_LSB  = 8;
  localparam int FCW_AVG_W    = 6;
  localparam int FCW_RAVG_BIT = 14;
  localparam int FCW_CHOP_BIT = 15;
  localparam logic [15:0] FCW_RESET = 16'h0007;

  // control register layout
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PM_LSB   = 3;
  localparam int CTRL_HREF_BIT = 5;
  localparam int CTRL_PGA_LSB  = 6;
  localparam int CTRL_OBIN_BIT = 10;

  // result register layout
  localparam int RES_OVF_BIT  = 16;
  localparam int RES_BUSY_BIT = 17;

  // coefficient scaling
  localparam logic [15:0] OFS_FACTORY_DEF = 16'h0000;
  localparam logic [15:0] GAIN_NOMINAL    = 16'h5555;
  localparam int OFS_SCALE_SH  = 8;
  localparam int GAIN_FRAC_SH  = 14;
  localparam int RND_SH        = 8;
  localparam int GAIN_NUM_SH   = 37;
  localparam logic [1:0] CONV_CHOP_OFF = 2'h3;
  localparam logic [1:0] CONV_CHOP_ON  = 2'h2;

  localparam logic [3:0] PGA_128 = 4'h7;
  localparam logic [3:0] PGA_512 = 4'h9;

  typedef enum logic [2:0] {
    MD_OFF = 3'h0, MD_CONT = 3'h1, MD_SINGLE = 3'h2, MD_IDLE = 3'h3,
    MD_SOFS = 3'h4, MD_SGAIN = 3'h5, MD_YOFS = 3'h6, MD_YGAIN = 3'h7
  } arc_mode_e;

  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_LP     = 2'h1;
  localparam logic [1:0] PM_LPP    = 2'h2;

  localparam logic [1:0] SRC_EXT  = 2'h0;
  localparam logic [1:0] SRC_ZERO = 2'h1;
  localparam logic [1:0] SRC_FS   = 2'h2;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001, ST_CALA = 4'b0010, ST_CALB = 4'b0100, ST_DIV = 4'b1000
  } arc_state_e;

  // log2 of the offset weighting factor
  function automatic logic [2:0] arc_kshift(input logic [1:0] pm, input logic [3:0] pga, input logic half_ref);
    logic [2:0] k;
    k = 3'h0;
    case (pm)
      PM_LP:   k = half_ref ? 3'h6 : 3'h5;
      PM_LPP:  k = half_ref ? 3'h4 : 3'h3;
      default: begin
        case (pga)
          4'h1, 4'h7: k = 3'h1;
          4'h8:       k = 3'h2;
          4'h9:       k = 3'h3;
          default:    k = 3'h0;
        endcase
      end
    endcase
    return k;
  endfunction

endpackage
`default_nettype wire

// >>> hw/arc_corr.sv
// offset, gain, rounding, clamping and formatting stage
`default_nettype none
module arc_corr import arc_pkg::*; #(
  parameter int DW = 24
) (
  input  wire logic                 hclk,      // bus clock
  input  wire logic                 hresetn,   // async reset, low
  input  wire logic                 in_valid,  // averaged sample strobe
  input  wire logic signed [DW-1:0] in_data,   // averaged sample
  input  wire logic [15:0]          ofs,       // offset coefficient
  input  wire logic [15:0]          gain,      // gain coefficient
  input  wire logic [2:0]           kshift,    // log2 offset weight
  input  wire logic                 obin,      // offset binary output
  output logic                      out_valid, // result strobe
  output logic [15:0]               out_data,  // formatted result
  output logic                      out_ovf    // result was clamped
);
  localparam int PW = DW + 26;
  localparam logic signed [PW-1:0] POS_FS = PW'(32767);
  localparam logic signed [PW-1:0] NEG_FS = -PW'(32768);

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        ovf;
  } arc_corr_s;

  arc_corr_s r_reg, r_next;

  always_comb begin
    logic signed [DW+7:0] off_t;
    logic signed [DW+8:0] diff;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] res;
    logic [15:0]          o;
    off_t = (DW+8)'($signed(ofs)) <<< (OFS_SCALE_SH + int'(kshift));
    diff = (DW+9)'(in_data) - (DW+9)'(off_t);
    prod = PW'(diff) * PW'($signed({1'b0, gain}));
    res = (prod + (PW'(1) <<< (GAIN_FRAC_SH + RND_SH - 1))) >>> (GAIN_FRAC_SH + RND_SH);
    r_next = r_reg;
    r_next.valid = in_valid;
    o = res[15:0];
    r_next.ovf = 1'b0;
    if (res > POS_FS) begin
      o = 16'h7fff;
      r_next.ovf = 1'b1;
    end else if (res < NEG_FS) begin
      o = 16'h8000;
      r_next.ovf = 1'b1;
    end
    if (in_valid) begin
      r_next.data = obin ? (o ^ 16'h8000) : o;
    end else begin
      r_next.ovf = r_reg.ovf;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_valid = r_reg.valid;
  assign out_data  = r_reg.data;
  assign out_ovf   = r_reg.ovf;
endmodule
`default_nettype wire

// >>> hw/arc_div.sv
// iterative unsigned restoring divider for the gain coefficient
`default_nettype none
module arc_div #(
  parameter int NW = 38,
  parameter int DDW = 33
) (
  input  wire logic           hclk,    // bus clock
  input  wire logic           hresetn, // async reset, low
  input  wire logic           start,   // begin division
  input  wire logic [NW-1:0]  num,     // dividend
  input  wire logic [DDW-1:0] den,     // divisor, nonzero
  output logic                done,    // quotient ready pulse
  output logic [NW-1:0]       quo      // quotient
);
  localparam int CW = $clog2(NW + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [DDW:0]  rem;
    logic [NW-1:0] q;
    logic          done;
  } arc_div_s;

  arc_div_s r_reg, r_next;

  always_comb begin
    logic [DDW:0] sh;
    sh = {r_reg.rem[DDW-1:0], r_reg.q[NW-1]};
    r_next = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.cnt = CW'(NW);
      r_next.rem = '0;
      r_next.q = num;
    end else if (r_reg.cnt != '0) begin
      if (sh >= {1'b0, den}) begin
        r_next.rem = sh - {1'b0, den};
        r_next.q = {r_reg.q[NW-2:0], 1'b1};
      end else begin
        r_next.rem = sh;
        r_next.q = {r_reg.q[NW-2:0], 1'b0};
      end
      r_next.cnt = r_reg.cnt - CW'(1);
      r_next.done = (r_reg.cnt == CW'(1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign quo  = r_reg.q;
endmodule
`default_nettype wire

// >>> hw/arc_top.sv
// result correction path and calibration sequencer with AHB-Lite registers
//
// Our own choices: register access over AHB-Lite and the address map.
`default_nettype none
module arc_top import arc_pkg::*; #(
  parameter int          DW          = 24,
  parameter int          AW          = 8,
  parameter logic [15:0] OFS_FACTORY  = OFS_FACTORY_DEF,
  parameter logic [15:0] GAIN_FACTORY = GAIN_NOMINAL
) (
  input  wire logic                 hclk,        // bus clock
  input  wire logic                 hresetn,     // async reset, low
  input  wire logic                 hsel,        // slave select
  input  wire logic [AW-1:0]        haddr,       // byte address
  input  wire logic [1:0]           htrans,      // transfer type
  input  wire logic                 hwrite,      // write access
  input  wire logic [2:0]           hsize,       // transfer size
  input  wire logic [31:0]          hwdata,      // write data
  input  wire logic                 hready,      // bus ready
  output logic [31:0]               hrdata,      // read data
  output logic                      hreadyout,   // slave ready
  output logic                      hresp,       // response, always okay
  input  wire logic                 flt_valid,   // decimation filter strobe
  input  wire logic signed [DW-1:0] flt_data,    // decimation filter output
  output logic [15:0]               flt_cfg,     // filter configuration word
  output logic                      flt_restart, // restart filter pulse
  output logic [1:0]                cal_src,     // input source select
  output logic                      mod_clk_lp,  // modulator on low-power clock
  output logic [3:0]                pga_code,    // effective amplifier gain code
  output logic                      conv_active, // conversions running
  output logic                      res_valid,   // result strobe
  output logic [15:0]               res_data,    // formatted result
  output logic                      res_ovf      // result was clamped
);
  localparam int NW  = GAIN_NUM_SH + 1;
  localparam int DDW = DW + 9;

  typedef struct packed {
    logic             ap_en;
    logic             ap_wr;
    logic [AW-1:0]    ap_addr;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic [15:0]      fcw;
    arc_mode_e        mode;
    logic [1:0]       pmode;
    logic             href;
    logic [3:0]       pga;
    logic             obin;
    logic [15:0]      ofs;
    logic [15:0]      gain;
    arc_state_e       st;
    logic [1:0]       cnt;
    logic [DW-1:0]    stage_a;
    logic [DW-1:0]    meas;
    logic             hold_v;
    logic [DW-1:0]    hold;
    logic [DW-1:0]    prev;
    logic             avg_v;
    logic [DW-1:0]    avg_d;
    logic             div_start;
    logic [15:0]      res;
    logic             ovf;
    logic             restart;
    logic [1:0]       src;
    logic             conv;
    logic             lp;
    logic [3:0]       pga_eff;
  } arc_top_s;

  localparam arc_top_s RESET_VAL = '{
    ap_en: 1'b0, ap_wr: 1'b0, ap_addr: '0, hrdata: 32'h0000_0000,
    hreadyout: 1'b1, hresp: 1'b0, fcw: FCW_RESET, mode: MD_IDLE,
    pmode: PM_NORMAL, href: 1'b0, pga: 4'h0, obin: 1'b0,
    ofs: OFS_FACTORY, gain: GAIN_FACTORY, st: ST_RUN, cnt: 2'h0,
    stage_a: '0, meas: '0, hold_v: 1'b0, hold: '0, prev: '0,
    avg_v: 1'b0, avg_d: '0, div_start: 1'b0, res: 16'h0000, ovf: 1'b0,
    restart: 1'b0, src: SRC_EXT, conv: 1'b0, lp: 1'b0, pga_eff: 4'h0
  };

  arc_top_s r_reg, r_next;

  logic [2:0]           kshift;
  logic signed [DW+7:0] ofs_term;
  logic signed [DDW-1:0] span;
  logic [DDW-1:0]       den;
  logic                 corr_valid;
  logic [15:0]          corr_data;
  logic                 corr_ovf;
  logic                 div_done;
  logic [NW-1:0]        div_quo;

  assign kshift = arc_kshift(r_reg.pmode, r_reg.pga, r_reg.href);
  assign ofs_term = (DW+8)'($signed(r_reg.ofs)) <<< (OFS_SCALE_SH + int'(kshift));

  // self gain measures its own zero; system gain relies on the offset coefficient
  assign span = (r_reg.mode == MD_SGAIN) ?
                (DDW'($signed(r_reg.meas)) - DDW'($signed(r_reg.stage_a))) :
                (DDW'($signed(r_reg.meas)) - DDW'(ofs_term));
  assign den = (span > 0) ? DDW'(span) : DDW'(1);

  function automatic logic is_cal(input arc_mode_e m);
    return m == MD_SOFS || m == MD_SGAIN || m == MD_YOFS || m == MD_YGAIN;
  endfunction

  function automatic logic is_gain(input arc_mode_e m);
    return m == MD_SGAIN || m == MD_YGAIN;
  endfunction

  always_comb begin
    logic          run_conv;
    logic          take;
    logic [DW:0]   sum;
    logic [1:0]    need;
    logic [31:0]   rd;
    logic          wr_ok;
    arc_mode_e     wm;
    run_conv = (r_reg.mode == MD_CONT || r_reg.mode == MD_SINGLE) && r_reg.st == ST_RUN;
    take = flt_valid && (run_conv || r_reg.st == ST_CALA || r_reg.st == ST_CALB);
    sum = '0;
    need = r_reg.fcw[FCW_CHOP_BIT] ? CONV_CHOP_ON : CONV_CHOP_OFF;
    rd = 32'h0000_0000;
    wr_ok = 1'b0;
    wm = MD_IDLE;
    r_next = r_reg;
    r_next.avg_v = 1'b0;
    r_next.div_start = 1'b0;
    r_next.restart = 1'b0;

    // averaging stage ahead of offset correction
    if (take) begin
      if (r_reg.fcw[FCW_CHOP_BIT]) begin
        if (!r_reg.hold_v) begin
          r_next.hold = flt_data;
          r_next.hold_v = 1'b1;
        end else begin
          sum = {r_reg.hold[DW-1], r_reg.hold} + {flt_data[DW-1], flt_data};
          r_next.avg_d = sum[DW:1];
          r_next.avg_v = 1'b1;
          r_next.hold_v = 1'b0;
        end
      end else if (r_reg.fcw[FCW_RAVG_BIT]) begin
        sum = {r_reg.prev[DW-1], r_reg.prev} + {flt_data[DW-1], flt_data};
        r_next.avg_d = sum[DW:1];
        r_next.prev = flt_data;
        r_next.avg_v = 1'b1;
      end else begin
        r_next.avg_d = flt_data;
        r_next.avg_v = 1'b1;
      end
    end

    // conversion results
    if (corr_valid && r_reg.st == ST_RUN) begin
      r_next.res = corr_data;
      r_next.ovf = corr_ovf;
      if (r_reg.mode == MD_SINGLE) begin
        r_next.mode = MD_IDLE;
      end
    end

    // calibration sequencer
    case (r_reg.st)
      ST_RUN: begin
      end
      ST_CALA: begin
        if (r_reg.avg_v) begin
          r_next.cnt = r_reg.cnt + 2'h1;
          if (r_reg.cnt == need - 2'h1) begin
            r_next.cnt = 2'h0;
            if (is_gain(r_reg.mode)) begin
              r_next.stage_a = r_reg.avg_d;
              r_next.st = ST_CALB;
              if (r_reg.mode == MD_SGAIN) begin
                r_next.src = SRC_FS;
              end
            end else begin
              r_next.ofs = 16'($signed(r_reg.avg_d) >>> (OFS_SCALE_SH + int'(kshift)));
              r_next.mode = MD_IDLE;
              r_next.st = ST_RUN;
              r_next.src = SRC_EXT;
            end
          end
        end
      end
      ST_CALB: begin
        if (r_reg.avg_v) begin
          r_next.cnt = r_reg.cnt + 2'h1;
          if (r_reg.cnt == need - 2'h1) begin
            r_next.cnt = 2'h0;
            r_next.meas = r_reg.avg_d;
            r_next.div_start = 1'b1;
            r_next.st = ST_DIV;
          end
        end
      end
      ST_DIV: begin
        if (div_done) begin
          r_next.gain = (|div_quo[NW-1:16]) ? 16'hffff : div_quo[15:0];
          r_next.mode = MD_IDLE;
          r_next.st = ST_RUN;
          r_next.src = SRC_EXT;
        end
      end
      default: begin
        r_next.st = ST_RUN;
      end
    endcase

    // register reads, prepared during the address phase
    case (haddr)
      FCW_OFS:  rd = {16'h0000, r_reg.fcw};
      CTRL_OFS: rd = {21'h0, r_reg.obin, r_reg.pga, r_reg.href, r_reg.pmode, r_reg.mode};
      OFSC_OFS: rd = {16'h0000, r_reg.ofs};
      GAIN_OFS: rd = {16'h0000, r_reg.gain};
      RES_OFS:  rd = {14'h0, r_reg.st != ST_RUN, r_reg.ovf, r_reg.res};
      default:  rd = 32'h0000_0000;
    endcase
    r_next.ap_en = hsel && htrans[1] && hready;
    if (r_next.ap_en) begin
      r_next.ap_wr = hwrite && hsize == 3'h2;
      r_next.ap_addr = haddr;
      r_next.hrdata = hwrite ? 32'h0000_0000 : rd;
    end

    // register writes in the data phase
    if (r_reg.ap_en && r_reg.ap_wr) begin
      wr_ok = r_next.mode == MD_IDLE && r_next.st == ST_RUN;
      case (r_reg.ap_addr)
        FCW_OFS: r_next.fcw = hwdata[15:0];
        CTRL_OFS: begin
          wm = arc_mode_e'(hwdata[CTRL_MODE_LSB +: 3]);
          r_next.mode = wm;
          r_next.pmode = hwdata[CTRL_PM_LSB +: 2];
          r_next.href = hwdata[CTRL_HREF_BIT];
          r_next.pga = hwdata[CTRL_PGA_LSB +: 4];
          r_next.obin = hwdata[CTRL_OBIN_BIT];
          r_next.cnt = 2'h0;
          r_next.hold_v = 1'b0;
          if (is_cal(wm)) begin
            r_next.st = ST_CALA;
            r_next.restart = 1'b1;
            r_next.src = (wm == MD_SOFS || wm == MD_SGAIN) ? SRC_ZERO : SRC_EXT;
          end else begin
            r_next.st = ST_RUN;
            r_next.src = SRC_EXT;
            r_next.restart = r_reg.st != ST_RUN;
          end
        end
        OFSC_OFS: begin
          if (wr_ok) begin
            r_next.ofs = hwdata[15:0];
          end
        end
        GAIN_OFS: begin
          if (wr_ok) begin
            r_next.gain = hwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end

    // mode-dependent amplifier and modulator clock selection
    r_next.lp = r_next.pmode != PM_NORMAL;
    r_next.pga_eff = (r_next.pmode == PM_LP) ? PGA_128 :
                     (r_next.pmode == PM_LPP) ? PGA_512 :
                     r_next.pga;
    r_next.conv = (r_next.mode == MD_CONT || r_next.mode == MD_SINGLE) && r_next.st == ST_RUN;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= RESET_VAL;
    end else begin
      r_reg <= r_next;
    end
  end

  arc_corr #(
    .DW (DW)
  ) u_corr (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (r_reg.avg_v && r_reg.conv),
    .in_data   ($signed(r_reg.avg_d)),
    .ofs       (r_reg.ofs),
    .gain      (r_reg.gain),
    .kshift    (kshift),
    .obin      (r_reg.obin),
    .out_valid (corr_valid),
    .out_data  (corr_data),
    .out_ovf   (corr_ovf)
  );

  arc_div #(
    .NW  (NW),
    .DDW (DDW)
  ) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (r_reg.div_start),
    .num     (NW'(1) << GAIN_NUM_SH),
    .den     (den),
    .done    (div_done),
    .quo     (div_quo)
  );

  assign hrdata      = r_reg.hrdata;
  assign hreadyout   = r_reg.hreadyout;
  assign hresp       = r_reg.hresp;
  assign flt_cfg     = r_reg.fcw;
  assign flt_restart = r_reg.restart;
  assign cal_src     = r_reg.src;
  assign mod_clk_lp  = r_reg.lp;
  assign pga_code    = r_reg.pga_eff;
  assign conv_active = r_reg.conv;
  assign res_valid   = corr_valid;
  assign res_data    = corr_data;
  assign res_ovf     = corr_ovf;
endmodule
`default_nettype wire

// >>> tb/arc_flt_model.sv
// stand-in for the decimation filter output stream
`default_nettype none
module arc_flt_model (
  input  wire logic               hclk,      // clock
  input  wire logic               hresetn,   // reset
  input  wire logic               send,      // emit one sample
  input  wire logic signed [23:0] smp_val,   // sample value
  output logic                    flt_valid, // sample strobe
  output logic signed [23:0]      flt_data   // sample out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_valid <= 1'b0;
      flt_data  <= 24'sh0;
    end else begin
      flt_valid <= send;
      flt_data  <= send ? smp_val : ~flt_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/arc_top_chk.sv
// port assertions for the result correction block
`default_nettype none
module arc_top_chk import arc_pkg::*; (
  input wire logic        hclk,        // clock
  input wire logic        hresetn,     // reset
  input wire logic        hreadyout,   // ready
  input wire logic        hresp,       // response
  input wire logic        flt_valid,   // strobe in
  input wire logic [15:0] flt_cfg,     // filter word
  input wire logic        flt_restart, // restart
  input wire logic [1:0]  cal_src,     // source
  input wire logic        mod_clk_lp,  // lp clock
  input wire logic [3:0]  pga_code,    // gain code
  input wire logic        conv_active, // running
  input wire logic        res_valid,   // strobe out
  input wire logic [15:0] res_data,    // result
  input wire logic        res_ovf      // clamped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_result_lat: assert property (flt_valid && conv_active && flt_cfg[15:14] == 2'h0 |-> ##2 res_valid)
    else $error("result not two edges after sample");
  a_chop_pair: assert property (flt_cfg[15] && res_valid |-> $past(flt_valid, 2))
    else $error("chop result without sample");
  a_result_hold: assert property (!res_valid |-> $stable(res_data))
    else $error("result moved without strobe");
  a_clamp_value: assert property (res_ovf |-> res_data inside {16'h7fff, 16'h8000, 16'hffff, 16'h0000})
    else $error("overflow without full scale");
  a_cal_halts: assert property (cal_src != SRC_EXT |-> !conv_active)
    else $error("conversion during calibration");
  a_lp_gain: assert property (mod_clk_lp |-> pga_code == PGA_128 || pga_code == PGA_512)
    else $error("low power gain not fixed");
  a_cal_restart: assert property ($rose(cal_src == SRC_ZERO) |-> flt_restart || $past(flt_restart))
    else $error("calibration without restart");
  c_ovf: cover property (res_valid && res_ovf);
  c_restart: cover property (flt_restart);
  c_lp_result: cover property (mod_clk_lp && res_valid);
endmodule
bind arc_top arc_top_chk arc_top_chk_i (.hclk, .hresetn, .hreadyout, .hresp, .flt_valid, .flt_cfg, .flt_restart,
  .cal_src, .mod_clk_lp, .pga_code, .conv_active, .res_valid, .res_data, .res_ovf);
`default_nettype wire

// >>> tb/arc_top_tb.sv
// testbench for the result correction block
`default_nettype none
module arc_top_tb import arc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0;
  logic [7:0]         haddr = 8'h00;
  logic [1:0]         htrans = 2'h0, cal_src;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0, hrdata, q;
  logic               hreadyout, hresp, flt_valid, flt_restart, mod_clk_lp, conv_active, res_valid, res_ovf;
  logic signed [23:0] flt_data, smp_val = 24'sh0;
  logic [15:0]        flt_cfg, res_data;
  logic [3:0]         pga_code;
  int                 n_errors = 0, compares = 0;
  int                 kk [14] = '{0, 1, 0, 0, 0, 0, 0, 1, 2, 3, 5, 6, 3, 4};
  int                 lc [4] = '{'h09, 'h29, 'h11, 'h31};
  logic [15:0]        cx [4] = '{16'h12, 16'h8000, 16'h24, 16'h5555};
  always #4 hclk = ~hclk;
  arc_top arc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .flt_valid, .flt_data, .flt_cfg, .flt_restart, .cal_src, .mod_clk_lp,
    .pga_code, .conv_active, .res_valid, .res_data, .res_ovf);
  arc_flt_model arc_flt_model_i (.hclk, .hresetn, .send, .smp_val, .flt_valid, .flt_data);
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic smp(input logic signed [23:0] x);
    send    <= 1'b1;
    smp_val <= x;
    @(posedge hclk);
    send <= 1'b0;
    @(posedge hclk);
  endtask
  // {overflow, result} from offset, gain over 2^14, rounding and clamp
  function automatic logic [16:0] expv(input longint x, input longint o, input int k, input logic ob);
    longint r;
    logic   v;
    r = ((x - (o <<< (8 + k))) * 21845 + 64'sh200000) >>> 22;
    v = r > 32767 || r < -32768;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return {v, 16'(r) ^ {ob, 15'h0}};
  endfunction
  task automatic get(input logic [16:0] e);
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      #1;
      i++;
    end while (res_valid !== 1'b1 && i < 12);
    chk("res_valid", 32'h1, 32'(res_valid));
    chk("result", 32'(e), {15'h0, res_ovf, res_data});
    @(posedge hclk);
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(FCW_OFS, 32'h7, "fcw");
    rd(OFSC_OFS, 32'h0, "ofs");
    rd(GAIN_OFS, 32'h5555, "gain");
    rd(8'h20, 32'h0, "unmapped");
    bus(1'b1, FCW_OFS, 32'h4000);
    rd(FCW_OFS, 32'h4000, "fcw");
    chk("flt_cfg", 32'h4000, 32'(flt_cfg));
    bus(1'b1, FCW_OFS, 32'h0);
    bus(1'b1, CTRL_OFS, 32'h1);
    smp(24'sh300000);
    get(expv(24'sh300000, 0, 0, 1'b0));
    smp(24'sh7fffff);
    get(expv(24'sh7fffff, 0, 0, 1'b0));
    smp(24'sh800000);
    get(expv(24'sh800000, 0, 0, 1'b0));
    bus(1'b1, CTRL_OFS, 32'h401);
    smp(24'sh300000);
    get(expv(24'sh300000, 0, 0, 1'b1));
    bus(1'b1, OFSC_OFS, 32'h55);
    rd(OFSC_OFS, 32'h0, "ofs locked");
    bus(1'b1, CTRL_OFS, 32'h3);
    bus(1'b1, OFSC_OFS, 32'h1);
    rd(OFSC_OFS, 32'h1, "ofs idle");
    for (int j = 0; j < 14; j++) begin
      bus(1'b1, CTRL_OFS, j < 10 ? 32'(1 | j << 6) : 32'(lc[j - 10]));
      smp(24'sh100000);
      get(expv(24'sh100000, 1, kk[j], 1'b0));
      chk("pga", j < 10 ? 32'(j) : j < 12 ? 32'(PGA_128) : 32'(PGA_512), 32'(pga_code));
      chk("lpclk", 32'(j >= 10), 32'(mod_clk_lp));
    end
    bus(1'b1, FCW_OFS, 32'h8000);
    bus(1'b1, CTRL_OFS, 32'h1);
    smp(24'sh200000);
    smp(24'sh100000);
    get(expv(24'sh180000, 1, 0, 1'b0));
    bus(1'b1, FCW_OFS, 32'h4000);
    smp(24'sh200000);
    smp(24'sh100000);
    get(expv(24'sh180000, 1, 0, 1'b0));
    bus(1'b1, CTRL_OFS, 32'h3);
    bus(1'b1, FCW_OFS, 32'h7f);
    bus(1'b1, GAIN_OFS, 32'h5555);
    for (int m = 4; m < 8; m++) begin
      bus(1'b1, CTRL_OFS, 32'(m));
      smp(m == 4 ? 24'sh001200 : m == 6 ? 24'sh002400 : 24'sh0);
      chk("src", m < 6 ? 32'(SRC_ZERO) : 32'(SRC_EXT), 32'(cal_src));
      smp(m == 4 ? 24'sh001200 : m == 6 ? 24'sh002400 : 24'sh0);
      bus(1'b0, RES_OFS, 32'h0);
      chk("busy", 32'h1, 32'(q[RES_BUSY_BIT]));
      rd(CTRL_OFS, 32'(m), "mode busy");
      smp(m == 4 ? 24'sh001200 : m == 6 ? 24'sh002400 : 24'sh0);
      if (m == 5 || m == 7) begin
        smp(m == 5 ? 24'sh400000 : 24'sh602400);
        chk("src", m == 5 ? 32'(SRC_FS) : 32'(SRC_EXT), 32'(cal_src));
        smp(m == 5 ? 24'sh400000 : 24'sh602400);
        rd(CTRL_OFS, 32'(m), "stage two");
        smp(m == 5 ? 24'sh400000 : 24'sh602400);
      end
      for (int i = 0; i < 40 && q[2:0] !== 3'h3; i++) bus(1'b0, CTRL_OFS, 32'h0);
      chk("idle", 32'h3, q);
      rd(m[0] ? GAIN_OFS : OFSC_OFS, 32'(cx[m - 4]), "coef");
    end
    give_verdict();
  end
endmodule
`default_nettype wire
